// ---- ilc_line_ctrl.sv ----
// Per-line interrupt, drive, pull-up, function select and direct write control
`timescale 1ns/100ps
`include "ilc_defs.svh"

// Overview of operation
// - Writing 1 to interrupt enable bit n enables change interrupt on line n.
// - Writing 1 to interrupt disable bit n disables change interrupt on line n.
// - Mask register reads 1 for enabled lines, 0 for disabled.
// - Status bit n sets on any change of line n since last read.
// - Reading status clears all bits; a change in that cycle survives.
// - Writing 1 to open-drain enable bit n puts line n in multi-drive.
// - Writing 1 to open-drain disable bit n restores push-pull drive.
// - Multi-drive lines drive low only; state register reports 1 when enabled.
// - Writing 1 to pull-up disable bit n turns off pull-up on line n.
// - Writing 1 to pull-up enable bit n turns on pull-up on line n.
// - Pull-up state reads 0 when enabled, 1 when disabled.
// - Writing 1 to first-function select bit n routes line n to function A.
// - Writing 1 to second-function select bit n routes line n to function B.
// - Function state reads 0 for function A, 1 for function B.
// - Writing 1 to direct write enable lets output level writes reach line n.
// - Writing 1 to direct write disable blocks output level writes on line n.
module ilc_line_ctrl
    import ilc_pkg::*;
#(
    parameter int NLINES = 32
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic [NLINES-1:0] line_bit_in,
    output logic [NLINES-1:0] line_bit_out,
    output logic [NLINES-1:0] line_bit_oe,
    output logic [NLINES-1:0] pullup_on,
    output logic [NLINES-1:0] func_second,
    output logic irq
);
    // ******************************
    // Bus decode
    // ******************************
    ilc_bus_s bus;
    assign bus = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};

    function automatic logic hit_wr(input ilc_bus_s b, input logic [7:0] off);
        return b.wr && (b.addr == off);
    endfunction

    wire logic [NLINES-1:0] wd = wdata[NLINES-1:0];
    wire logic w_irq_en = hit_wr(bus, `ILC_OFF_IRQ_EN);
    wire logic w_irq_dis = hit_wr(bus, `ILC_OFF_IRQ_DIS);
    wire logic w_od_en = hit_wr(bus, `ILC_OFF_OD_EN);
    wire logic w_od_dis = hit_wr(bus, `ILC_OFF_OD_DIS);
    wire logic w_pu_en = hit_wr(bus, `ILC_OFF_PU_EN);
    wire logic w_pu_dis = hit_wr(bus, `ILC_OFF_PU_DIS);
    wire logic w_fa = hit_wr(bus, `ILC_OFF_FA_SEL);
    wire logic w_fb = hit_wr(bus, `ILC_OFF_FB_SEL);
    wire logic w_dw_en = hit_wr(bus, `ILC_OFF_DW_EN);
    wire logic w_dw_dis = hit_wr(bus, `ILC_OFF_DW_DIS);
    wire logic w_out = hit_wr(bus, `ILC_OFF_OUT_LVL);
    wire logic r_stat = rd_stb && (addr == `ILC_OFF_IRQ_STAT);

    // ******************************
    // Control state
    // ******************************
    logic [NLINES-1:0] mask_r, mask_nxt;
    logic [NLINES-1:0] od_r, od_nxt;
    logic [NLINES-1:0] pu_off_r, pu_off_nxt;
    logic [NLINES-1:0] fsel_r, fsel_nxt;
    logic [NLINES-1:0] dw_r, dw_nxt;
    logic [NLINES-1:0] out_r, out_nxt;
    logic [NLINES-1:0] stat_r, stat_nxt;
    logic [NLINES-1:0] s1_r, s2_r, s3_r, prev_r;
    logic [31:0] rdata_r, rdata_nxt;

    assign mask_nxt = w_irq_en ? (mask_r | wd) :
                      w_irq_dis ? (mask_r & ~wd) : mask_r;
    assign od_nxt = w_od_en ? (od_r | wd) :
                    w_od_dis ? (od_r & ~wd) : od_r;
    assign pu_off_nxt = w_pu_dis ? (pu_off_r | wd) :
                        w_pu_en ? (pu_off_r & ~wd) : pu_off_r;
    assign fsel_nxt = w_fa ? (fsel_r & ~wd) :
                      w_fb ? (fsel_r | wd) : fsel_r;
    assign dw_nxt = w_dw_en ? (dw_r | wd) :
                    w_dw_dis ? (dw_r & ~wd) : dw_r;
    // Only lines with direct write enabled take the written level
    assign out_nxt = w_out ? ((out_r & ~dw_r) | (wd & dw_r)) : out_r;

    // ******************************
    // Change detection
    // ******************************
    // Per line: level moves only once second and third stages agree
    wire logic [NLINES-1:0] lvl;
    wire logic [NLINES-1:0] chg;
    genvar gi;
    generate
        for (gi = 0; gi < NLINES; gi = gi + 1) begin : g_line
            assign lvl[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : prev_r[gi];
            assign chg[gi] = lvl[gi] ^ prev_r[gi];
        end
    endgenerate
    // New change wins over the clear-on-read
    assign stat_nxt = (r_stat ? '0 : stat_r) | chg;

    // ******************************
    // Read mux
    // ******************************
    wire logic [31:0] od_rd = 32'(od_r);
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (addr)
            `ILC_OFF_IRQ_MASK: rdata_nxt = 32'(mask_r);
            `ILC_OFF_IRQ_STAT: rdata_nxt = 32'(stat_r);
            `ILC_OFF_OD_STATE: rdata_nxt = od_rd;
            `ILC_OFF_PU_STATE: rdata_nxt = 32'(pu_off_r);
            `ILC_OFF_F_STATE: rdata_nxt = 32'(fsel_r);
            `ILC_OFF_DW_STATE: rdata_nxt = 32'(dw_r);
            `ILC_OFF_OUT_LVL: rdata_nxt = 32'(out_r);
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mask_r <= NLINES'(`ILC_RST_MASK);
            od_r <= NLINES'(`ILC_RST_OD);
            pu_off_r <= NLINES'(`ILC_RST_PU_OFF);
            fsel_r <= NLINES'(`ILC_RST_FSEL);
            dw_r <= NLINES'(`ILC_RST_DW);
            out_r <= NLINES'(`ILC_RST_OUT);
            stat_r <= '0;
            rdata_r <= 32'h0000_0000;
        end else begin
            mask_r <= mask_nxt;
            od_r <= od_nxt;
            pu_off_r <= pu_off_nxt;
            fsel_r <= fsel_nxt;
            dw_r <= dw_nxt;
            out_r <= out_nxt;
            stat_r <= stat_nxt;
            rdata_r <= rd_stb ? rdata_nxt : 32'h0000_0000;
        end
    end

    // Synchronizer runs through reset so no false change follows release
    always_ff @(posedge mclk) begin
        s1_r <= line_bit_in;
        s2_r <= s1_r;
        s3_r <= s2_r;
        prev_r <= rstn ? lvl : s3_r;
    end

    // ******************************
    // Pad and outputs
    // ******************************
    assign rdata = rdata_r;
    // Multi-drive: drive only when low, release when high
    assign line_bit_out = out_r & ~od_r;
    assign line_bit_oe = (od_r & ~out_r) | ~od_r;
    assign pullup_on = ~pu_off_r;
    assign func_second = fsel_r;
    assign irq = |(stat_r & mask_r);

    // ******************************
    // Assertions
    // ******************************
    sequence s_en_write;
        w_irq_en && !w_irq_dis;
    endsequence
    a_irq_enable_sets: assert property (@(posedge mclk) disable iff (!rstn)
        s_en_write |=> ((mask_r & $past(wd)) == $past(wd)))
        else $error("enable write did not set mask");
    a_irq_disable_clr: assert property (@(posedge mclk) disable iff (!rstn)
        w_irq_dis |=> ((mask_r & $past(wd)) == '0))
        else $error("disable write did not clear mask");
    a_mask_read_back: assert property (@(posedge mclk) disable iff (!rstn)
        (rd_stb && addr == `ILC_OFF_IRQ_MASK) |=> rdata == 32'($past(mask_r)))
        else $error("mask read mismatch");
    a_change_sets_stat: assert property (@(posedge mclk) disable iff (!rstn)
        (chg != '0) |=> ((stat_r & $past(chg)) == $past(chg)))
        else $error("change not latched");
    a_read_clears_stat: assert property (@(posedge mclk) disable iff (!rstn)
        r_stat |=> stat_r == $past(chg))
        else $error("status not cleared by read");
    a_od_low_only: assert property (@(posedge mclk) disable iff (!rstn)
        !((od_r & line_bit_oe & line_bit_out) != '0))
        else $error("open-drain line driven high");
    a_od_set_clear: assert property (@(posedge mclk) disable iff (!rstn)
        (w_od_en |=> ((od_r & $past(wd)) == $past(wd))) and
        (w_od_dis |=> ((od_r & $past(wd)) == '0)))
        else $error("open-drain state wrong");
    a_pullup_sense: assert property (@(posedge mclk) disable iff (!rstn)
        w_pu_en |=> ((pullup_on & $past(wd)) == $past(wd)) ##1 1'b1)
        else $error("pull-up not enabled");
    a_pullup_off: assert property (@(posedge mclk) disable iff (!rstn)
        w_pu_dis |=> ((pu_off_r & $past(wd)) == $past(wd)))
        else $error("pull-up not disabled");
    a_func_select: assert property (@(posedge mclk) disable iff (!rstn)
        (w_fb |=> ((func_second & $past(wd)) == $past(wd))) and
        (w_fa |=> ((func_second & $past(wd)) == '0)))
        else $error("function select wrong");
    a_direct_write: assert property (@(posedge mclk) disable iff (!rstn)
        w_out |=> ((out_r ^ $past(out_r)) & ~$past(dw_r)) == '0)
        else $error("blocked line changed");
    a_irq_level: assert property (@(posedge mclk) disable iff (!rstn)
        (irq && r_stat && chg == '0) |=> !irq)
        else $error("irq not dropped after read");

    // ******************************
    // Assertions: set and clear registers
    // ******************************
    sequence s_read_of(logic [7:0] off);
        rd_stb && (addr == off);
    endsequence

    a_mask_en_keep: assert property (@(posedge mclk) disable iff (!rstn)
        w_irq_en |=> ((mask_r & ~$past(wd)) == ($past(mask_r) & ~$past(wd))))
        else $error("enable write touched a zero bit");

    a_mask_dis_keep: assert property (@(posedge mclk) disable iff (!rstn)
        w_irq_dis |=> ((mask_r & ~$past(wd)) == ($past(mask_r) & ~$past(wd))))
        else $error("disable write touched a zero bit");

    a_od_keep_zero: assert property (@(posedge mclk) disable iff (!rstn)
        (w_od_en || w_od_dis) |=> (((od_r ^ $past(od_r)) & ~$past(wd)) == '0))
        else $error("open-drain zero bit changed");

    a_od_state_read: assert property (@(posedge mclk) disable iff (!rstn)
        s_read_of(`ILC_OFF_OD_STATE) |=> (rdata == 32'($past(od_r))))
        else $error("open-drain state read mismatch");

    a_od_drive_low: assert property (@(posedge mclk) disable iff (!rstn)
        ((od_r & ~out_r & ~line_bit_oe) == '0))
        else $error("open-drain line not driven low");

    a_push_pull_drive: assert property (@(posedge mclk) disable iff (!rstn)
        ((~od_r & (~line_bit_oe | (line_bit_out ^ out_r))) == '0))
        else $error("push-pull line not driven to level");

    // ******************************
    // Assertions: pull-up and function select
    // ******************************
    a_pu_keep_zero: assert property (@(posedge mclk) disable iff (!rstn)
        (w_pu_en || w_pu_dis) |=> (((pu_off_r ^ $past(pu_off_r)) & ~$past(wd)) == '0))
        else $error("pull-up zero bit changed");

    a_pu_enable_clr: assert property (@(posedge mclk) disable iff (!rstn)
        w_pu_en |=> ((pu_off_r & $past(wd)) == '0))
        else $error("pull-up state not cleared");

    a_pu_state_read: assert property (@(posedge mclk) disable iff (!rstn)
        s_read_of(`ILC_OFF_PU_STATE) |=> (rdata == 32'(~$past(pullup_on))))
        else $error("pull-up state sense wrong");

    a_func_keep_zero: assert property (@(posedge mclk) disable iff (!rstn)
        (w_fa || w_fb) |=> (((func_second ^ $past(func_second)) & ~$past(wd)) == '0))
        else $error("function zero bit changed");

    a_func_a_route: assert property (@(posedge mclk) disable iff (!rstn)
        w_fa |=> ((fsel_r & $past(wd)) == '0))
        else $error("line not routed to first function");

    a_func_state_read: assert property (@(posedge mclk) disable iff (!rstn)
        s_read_of(`ILC_OFF_F_STATE) |=> (rdata == 32'($past(func_second))))
        else $error("function state read mismatch");

    // ******************************
    // Assertions: direct write
    // ******************************
    a_dw_enable_set: assert property (@(posedge mclk) disable iff (!rstn)
        w_dw_en |=> ((dw_r & $past(wd)) == $past(wd)))
        else $error("direct write not enabled");

    a_dw_disable_clr: assert property (@(posedge mclk) disable iff (!rstn)
        w_dw_dis |=> ((dw_r & $past(wd)) == '0))
        else $error("direct write not disabled");

    a_dw_pass_level: assert property (@(posedge mclk) disable iff (!rstn)
        w_out |=> (((out_r ^ $past(wd)) & $past(dw_r)) == '0))
        else $error("enabled line missed written level");

    // ******************************
    // Assertions: change status and interrupt
    // ******************************
    sequence s_masked_change;
        ((chg & mask_r) != '0) && !w_irq_dis;
    endsequence

    a_stat_read_value: assert property (@(posedge mclk) disable iff (!rstn)
        s_read_of(`ILC_OFF_IRQ_STAT) |=> (rdata == 32'($past(stat_r))))
        else $error("status read mismatch");

    a_stat_hold: assert property (@(posedge mclk) disable iff (!rstn)
        (!r_stat && (chg == '0)) |=> (stat_r == $past(stat_r)))
        else $error("status moved without change or read");

    a_stat_no_false: assert property (@(posedge mclk) disable iff (!rstn)
        ((stat_r & ~$past(chg) & ~$past(stat_r)) == '0))
        else $error("status bit set without change");

    a_sync_follow: assert property (@(posedge mclk) disable iff (!rstn)
        (s2_r == s3_r) |=> (prev_r == $past(s3_r)))
        else $error("settled level not taken");

    a_sync_hold: assert property (@(posedge mclk) disable iff (!rstn)
        1'b1 |=> (((prev_r ^ $past(prev_r)) & $past(s2_r ^ s3_r)) == '0))
        else $error("unsettled line moved level");

    a_irq_raise: assert property (@(posedge mclk) disable iff (!rstn)
        s_masked_change |=> irq)
        else $error("masked change did not raise irq");

    a_irq_hold: assert property (@(posedge mclk) disable iff (!rstn)
        (irq && !r_stat && !w_irq_dis) |=> irq)
        else $error("irq dropped before status read");
endmodule

// ---- ilc_defs.svh ----
// Register offsets and reset values for the line control block
`ifndef ILC_DEFS_SVH
`define ILC_DEFS_SVH
`define ILC_OFF_IRQ_EN 8'h00
`define ILC_OFF_IRQ_DIS 8'h04
`define ILC_OFF_IRQ_MASK 8'h08
`define ILC_OFF_IRQ_STAT 8'h0c
`define ILC_OFF_OD_EN 8'h10
`define ILC_OFF_OD_DIS 8'h14
`define ILC_OFF_OD_STATE 8'h18
`define ILC_OFF_PU_DIS 8'h20
`define ILC_OFF_PU_EN 8'h24
`define ILC_OFF_PU_STATE 8'h28
`define ILC_OFF_FA_SEL 8'h30
`define ILC_OFF_FB_SEL 8'h34
`define ILC_OFF_F_STATE 8'h38
`define ILC_OFF_DW_EN 8'h40
`define ILC_OFF_DW_DIS 8'h44
`define ILC_OFF_DW_STATE 8'h48
`define ILC_OFF_OUT_LVL 8'h4c
`define ILC_RST_MASK 32'h0000_0000
`define ILC_RST_OD 32'h0000_0000
`define ILC_RST_PU_OFF 32'h0000_0000
`define ILC_RST_FSEL 32'h0000_0000
`define ILC_RST_DW 32'h0000_0000
`define ILC_RST_OUT 32'h0000_0000
`endif

// ---- ilc_pkg.sv ----
// Types shared by the line control block
package ilc_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ilc_bus_s;
    typedef struct packed {
        logic [31:0] level;
        logic [31:0] oe;
    } ilc_pad_s;
endpackage

// ---- ilc_pad_model.sv ----
// Pad and external-party model for the line control block
`timescale 1ns/100ps
module ilc_pad_model
    import ilc_pkg::*;
(
    input wire logic mclk,
    input wire logic [31:0] line_bit_out,
    input wire logic [31:0] line_bit_oe,
    input wire logic [31:0] pullup_on,
    input wire logic [31:0] ext_low,
    output logic [31:0] line_bit_in
);
    logic [31:0] prev_r = 32'h0;
    logic [31:0] pulled_low;
    logic [31:0] driven_high;
    logic [31:0] floating;
    // Wired-AND pad: either party may pull low, only the block drives high
    assign pulled_low = (line_bit_oe & ~line_bit_out) | ext_low;
    assign driven_high = line_bit_oe & line_bit_out & ~ext_low;
    assign floating = ~line_bit_oe & ~ext_low;
    // Undriven line without pull-up wanders instead of holding its value
    assign line_bit_in = ~pulled_low & (driven_high | (floating & (pullup_on | ~prev_r)));
    always @(posedge mclk) begin
        prev_r <= line_bit_in;
    end
endmodule

// ---- testbench.sv ----
// Register-level bench for the line control block
`timescale 1ns/100ps
`include "ilc_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module testbench;
    import ilc_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [31:0] ext_low = 32'h0;
    logic [31:0] rdata, pin_in, pin_out, pin_oe, pu_on, f_b;
    logic irq;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    always #12.5 mclk = ~mclk;
    ilc_line_ctrl dut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .line_bit_in(pin_in),
        .line_bit_out(pin_out), .line_bit_oe(pin_oe), .pullup_on(pu_on),
        .func_second(f_b), .irq(irq));
    ilc_pad_model pads (.mclk(mclk), .line_bit_out(pin_out), .line_bit_oe(pin_oe),
        .pullup_on(pu_on), .ext_low(ext_low), .line_bit_in(pin_in));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        rd(`ILC_OFF_IRQ_MASK, 32'h0);
        rd(`ILC_OFF_OD_STATE, 32'h0);
        rd(`ILC_OFF_PU_STATE, 32'h0);
        rd(`ILC_OFF_F_STATE, 32'h0);
        rd(`ILC_OFF_IRQ_STAT, 32'h0);
        rd(8'hfc, 32'h0);
        `CHK(pin_oe, 32'hffff_ffff)
        $display("test reset done");
        wr(`ILC_OFF_IRQ_EN, 32'h0000_00f0);
        wr(`ILC_OFF_IRQ_EN, 32'h0000_000f);
        rd(`ILC_OFF_IRQ_MASK, 32'h0000_00ff);
        wr(`ILC_OFF_IRQ_DIS, 32'h0000_0011);
        wr(`ILC_OFF_IRQ_MASK, 32'hffff_ffff);
        rd(`ILC_OFF_IRQ_MASK, 32'h0000_00ee);
        $display("test mask done");
        wr(`ILC_OFF_PU_DIS, 32'h0000_0005);
        rd(`ILC_OFF_PU_STATE, 32'h0000_0005);
        `CHK(pu_on, 32'hffff_fffa)
        wr(`ILC_OFF_PU_EN, 32'h0000_0001);
        rd(`ILC_OFF_PU_STATE, 32'h0000_0004);
        wr(`ILC_OFF_FB_SEL, 32'h0000_000c);
        rd(`ILC_OFF_F_STATE, 32'h0000_000c);
        `CHK(f_b, 32'h0000_000c)
        wr(`ILC_OFF_FA_SEL, 32'h0000_0004);
        rd(`ILC_OFF_F_STATE, 32'h0000_0008);
        $display("test pull and function done");
        wr(`ILC_OFF_DW_EN, 32'h0000_0310);
        wr(`ILC_OFF_OUT_LVL, 32'hffff_ffff);
        rd(`ILC_OFF_OUT_LVL, 32'h0000_0310);
        wr(`ILC_OFF_OD_EN, 32'h0000_0300);
        rd(`ILC_OFF_OD_STATE, 32'h0000_0300);
        `CHK(pin_oe, 32'hffff_fcff)
        wr(`ILC_OFF_OD_DIS, 32'h0000_0200);
        rd(`ILC_OFF_OD_STATE, 32'h0000_0100);
        `CHK(pin_oe, 32'hffff_feff)
        wr(`ILC_OFF_DW_DIS, 32'h0000_0010);
        wr(`ILC_OFF_OUT_LVL, 32'h0);
        rd(`ILC_OFF_OUT_LVL, 32'h0000_0010);
        rd(`ILC_OFF_DW_STATE, 32'h0000_0300);
        `CHK(pin_out, 32'h0000_0010)
        `CHK(pin_oe, 32'hffff_ffff)
        $display("test drive done");
        idle(8);
        `CHK(irq, 1'b0)
        rd(`ILC_OFF_IRQ_STAT, 32'h0000_0310);
        rd(`ILC_OFF_IRQ_STAT, 32'h0);
        wr(`ILC_OFF_IRQ_EN, 32'h0000_0100);
        wr(`ILC_OFF_OUT_LVL, 32'h0000_0100);
        idle(8);
        `CHK(pin_oe[8], 1'b0)
        `CHK(irq, 1'b1)
        ext_low <= 32'h0000_0100;
        idle(8);
        `CHK(irq, 1'b1)
        rd(`ILC_OFF_IRQ_STAT, 32'h0000_0100);
        `CHK(irq, 1'b0)
        rd(`ILC_OFF_IRQ_STAT, 32'h0);
        $display("test change done");
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        rd(`ILC_OFF_IRQ_MASK, 32'h0);
        rd(`ILC_OFF_OUT_LVL, 32'h0);
        rd(`ILC_OFF_IRQ_STAT, 32'h0);
        `CHK(irq, 1'b0)
        `CHK(pin_oe, 32'hffff_ffff)
        $display("test reset again done");
        tally_and_finish;
    end
endmodule
